//--- include/vicom_map.svh
// Register map, field positions, reset values and fixed constants of the video input mixer
`ifndef VICOM_MAP_SVH
`define VICOM_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VICOM_REG_CTRL      8'h00
`define VICOM_REG_STATUS    8'h04

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define VICOM_CTRL_FMT      2:0
`define VICOM_CTRL_LIN      3
`define VICOM_CTRL_GSEL     4
`define VICOM_CTRL_MIX      6:5
`define VICOM_CTRL_MASK     32'h0000_007f
`define VICOM_CTRL_RST      32'h0000_0000

// ****************************************************************
// Status register fields
// ****************************************************************
`define VICOM_STAT_CNT      15:0
`define VICOM_STAT_OVL      16

// ****************************************************************
// Gamma exponents (output = input ** (1 / value))
// ****************************************************************
`define VICOM_GAMMA_A       2.2
`define VICOM_GAMMA_B       2.8

// ****************************************************************
// Blend weights in eighths of overlay colour
// ****************************************************************
`define VICOM_W_ZERO        4'h0
`define VICOM_W_LOW         4'h1
`define VICOM_W_HIGH        4'h7
`define VICOM_W_FULL        4'h8

// ****************************************************************
// Colour conversion coefficients (scaled by 256) and offsets
// ****************************************************************
`define VICOM_Y_R           10'sd66
`define VICOM_Y_G           10'sd129
`define VICOM_Y_B           10'sd25
`define VICOM_CB_R          -10'sd38
`define VICOM_CB_G          -10'sd74
`define VICOM_CB_B          10'sd112
`define VICOM_CR_R          10'sd112
`define VICOM_CR_G          -10'sd94
`define VICOM_CR_B          -10'sd18
`define VICOM_Y_OFF         8'h10
`define VICOM_C_OFF         8'h80

// ****************************************************************
// Overlay palette as {Y, Cb, Cr}
// ****************************************************************
`define VICOM_OVL_BLUE      24'h23_d472
`define VICOM_OVL_RED       24'h51_5af0
`define VICOM_OVL_MAGENTA   24'h6a_cade
`define VICOM_OVL_GREEN     24'h70_3622
`define VICOM_OVL_CYAN      24'haa_a610
`define VICOM_OVL_YELLOW    24'ha2_2c8e
`define VICOM_OVL_WHITE     24'heb_8080

`endif

//--- include/vicom_pkg.sv
// Types shared by the video input mixer modules
package vicom_pkg;

	// Input format selection
	typedef enum logic [2:0] {
		VICOM_FMT_YC16  = 3'b000,
		VICOM_FMT_YC8   = 3'b001,
		VICOM_FMT_BT656 = 3'b010,
		VICOM_FMT_RGB16 = 3'b011,
		VICOM_FMT_RGB24 = 3'b100
	} vicom_fmt_e;

	// Overlay mixing method
	typedef enum logic [1:0] {
		VICOM_MIX_OFF  = 2'b00,
		VICOM_MIX_EXT  = 2'b01,
		VICOM_MIX_INT  = 2'b10,
		VICOM_MIX_HARD = 2'b11
	} vicom_mix_e;

	// One 8-bit video sample
	typedef logic [7:0] vicom_smp_t;

endpackage : vicom_pkg

//--- sim/vicom_mixer_monitor.sv
// Port checker for the video input mixer
`timescale 1ns/100ps
`include "vicom_map.svh"
module vicom_mixer_monitor (
	input wire logic                  ref_clk_i,
	input wire logic                  sys_rst_i,
	input wire logic [7:0]            reg_addr_i,
	input wire logic [31:0]           reg_wdata_i,
	input wire logic                  reg_wr_i,
	input wire logic                  reg_rd_i,
	input wire logic [31:0]           reg_rdata_o,
	input wire logic                  pixel_valid_i,
	input wire logic [23:0]           pixel_input_bus_i,
	input wire logic [2:0]            overlay_color_select_i,
	input wire logic                  out_valid_o,
	input wire vicom_pkg::vicom_smp_t out_y_o,
	input wire vicom_pkg::vicom_smp_t out_cb_o,
	input wire vicom_pkg::vicom_smp_t out_cr_o
);
	import vicom_pkg::*;
	logic [6:0] ctrl_q;
	// ****
	// Control mirror
	// ****
	// Track control writes to know the active format and mixing method
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			ctrl_q <= 7'h00;
		else if (reg_wr_i && reg_addr_i == `VICOM_REG_CTRL)
			ctrl_q <= reg_wdata_i[6:0];
	end
	// ****
	// Assertions
	// ****
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
		else $error("read data not zero outside read slot");
	a_ctrl_upper_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) == `VICOM_REG_CTRL
		|-> reg_rdata_o[31:7] == 25'h0) else $error("control upper bits not zero");
	a_unmapped_zero: assert property ($past(reg_rd_i)
		&& !($past(reg_addr_i) inside {`VICOM_REG_CTRL, `VICOM_REG_STATUS}) |-> reg_rdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_out_latency: assert property (pixel_valid_i && !(ctrl_q[2:0] inside {3'h1, 3'h2}) |-> ##6 out_valid_o)
		else $error("output pixel missing six cycles after input");
	a_hold_stable: assert property (!out_valid_o |-> $stable({out_y_o, out_cb_o, out_cr_o}))
		else $error("output changed without valid");
	a_off_y_pass: assert property (out_valid_o && ctrl_q[6:5] == VICOM_MIX_OFF && ctrl_q[2:0] == 3'h0
		&& $past(pixel_input_bus_i[15:12], 6) != 4'h0 |-> out_y_o == $past(pixel_input_bus_i[15:8], 6))
		else $error("luma altered with mixing disabled");
	a_hard_white: assert property (out_valid_o && ctrl_q[6:5] == VICOM_MIX_HARD && ctrl_q[2:0] == 3'h0
		&& $past(overlay_color_select_i, 6) == 3'h7 |-> {out_y_o, out_cb_o, out_cr_o} == `VICOM_OVL_WHITE)
		else $error("hard overlay white wrong");
	a_rgb24_black: assert property (out_valid_o && ctrl_q[2:0] == 3'h4
		&& $past(pixel_input_bus_i, 6) == 24'h00_0000 |-> {out_y_o, out_cb_o, out_cr_o} == 24'h10_8080)
		else $error("wide rgb black wrong or overlaid");
endmodule : vicom_mixer_monitor

bind vicom_mixer vicom_mixer_monitor mon_u (.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .pixel_valid_i, .pixel_input_bus_i, .overlay_color_select_i, .out_valid_o,
	.out_y_o, .out_cb_o, .out_cr_o);

//--- sim/vicom_mixer_tb_top.sv
// Self-checking bench for the video input mixer
`timescale 1ns/100ps
`include "vicom_map.svh"
module vicom_mixer_tb_top;
	import vicom_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic        pixel_valid_i, mix_level_lsb_i, mix_level_msb_i, out_valid_o;
	logic [23:0] pixel_input_bus_i;
	logic [2:0]  overlay_color_select_i;
	vicom_smp_t  out_y_o, out_cb_o, out_cr_o;
	logic [23:0] got_q[$], exp_q[$];
	logic [23:0] pal[8] = '{24'h00_0000, `VICOM_OVL_BLUE, `VICOM_OVL_RED, `VICOM_OVL_MAGENTA,
		`VICOM_OVL_GREEN, `VICOM_OVL_CYAN, `VICOM_OVL_YELLOW, `VICOM_OVL_WHITE};
	int          wx[4] = '{0, 1, 7, 8};
	int          mismatches = 0, cmp_count = 0;
	int          cyc = 0, total = 0;

	always #2.5 ref_clk_i = ~ref_clk_i;

	vicom_mixer dut_u (.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.pixel_valid_i, .pixel_input_bus_i, .overlay_color_select_i, .mix_level_lsb_i, .mix_level_msb_i,
		.out_valid_o, .out_y_o, .out_cb_o, .out_cr_o);
	vicom_pix_src src_u (.ref_clk_i, .pixel_valid_o(pixel_valid_i), .pixel_input_bus_o(pixel_input_bus_i),
		.overlay_color_select_o(overlay_color_select_i), .mix_level_o({mix_level_msb_i, mix_level_lsb_i}));

	// ****
	// Helpers
	// ****
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	function automatic logic [23:0] mix(input logic [23:0] a, input logic [23:0] b, input int w);
		for (int k = 0; k < 24; k += 8)
			mix[k +: 8] = 8'((a[k +: 8] * w + b[k +: 8] * (8 - w) + 4) >> 3);
	endfunction : mix
	// Send a run of codes (one hex digit each), flush, compare pixels and status
	task automatic run(input logic [63:0] cv, input logic [63:0] lvv, input int len, input vicom_mix_e m,
		input logic [4:0] f = 5'h00, input logic [23:0] px = 24'h50_7090, input logic [23:0] ex = 24'h50_7090);
		logic [2:0]  c[17];
		logic [1:0]  lv;
		logic [23:0] base, e;
		logic [31:0] d;
		int          p, n;
		c[len] = 3'h0;
		for (int i = 0; i < len; i++)
			c[i] = cv[4 * (len - 1 - i) +: 3];
		wr(`VICOM_REG_CTRL, {25'h0, m, f});
		for (int i = 0; i < len; i++) begin
			lv = lvv[4 * (len - 1 - i) +: 2];
			p = (i > 0) ? c[i - 1] : 0;
			n = c[i + 1];
			base = ex;
			if (f == 5'h00)
				base[15:8] = ex[15:8] + 8'(8 * (i - i % 2 * (i + 1 == len)));
			src_u.send(f == 5'h00 ? {8'h00, px[23:16], i[0] ? px[7:0] : base[15:8]} : px, c[i], lv);
			e = base;
			if (m == VICOM_MIX_HARD && c[i] != 0 && f[2:0] != 3'h4)
				e = pal[c[i]];
			if (m == VICOM_MIX_EXT && c[i] != 0)
				e = mix(pal[c[i]], base, wx[lv]);
			if (m == VICOM_MIX_INT && c[i] == 0 && p != 0)
				e = mix(pal[p], base, 1);
			else if (m == VICOM_MIX_INT && c[i] == 0 && n != 0)
				e = mix(pal[n], base, 1);
			else if (m == VICOM_MIX_INT && c[i] != p)
				e = mix(pal[c[i]], p != 0 ? pal[p] : base, 7);
			else if (m == VICOM_MIX_INT && c[i] != 0 && n == 0)
				e = mix(pal[c[i]], base, 7);
			else if (m == VICOM_MIX_INT && c[i] != 0 && n != c[i])
				e = mix(pal[n], pal[c[i]], 1);
			else if (m == VICOM_MIX_INT && c[i] != 0)
				e = pal[c[i]];
			exp_q.push_back(e);
		end
		src_u.idle(4);
		repeat (4) @(posedge ref_clk_i);
		total += len;
		check(got_q.size(), len);
		while (got_q.size() > 0 && exp_q.size() > 0)
			check(got_q.pop_front(), exp_q.pop_front());
		got_q.delete();
		exp_q.delete();
		rd(`VICOM_REG_STATUS, d);
		check(d, {15'h0, e !== base, total[15:0]});
		$display("test with mix %0d done", m);
	endtask : run

	// Capture output pixels and cut a hang short
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (out_valid_o === 1'b1)
			got_q.push_back({out_y_o, out_cb_o, out_cr_o});
		if (cyc == 5000) begin
			mismatches++;
			conclude();
		end
	end

	// ****
	// Main sequence
	// ****
	initial begin
		logic [31:0] d;
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd(`VICOM_REG_CTRL, d);
		check(d, `VICOM_CTRL_RST);
		wr(`VICOM_REG_STATUS, 32'hffff_ffff);
		rd(`VICOM_REG_STATUS, d);
		check(d, 32'h0000_0000);
		rd(8'h08, d);
		check(d, 32'h0000_0000);
		wr(`VICOM_REG_CTRL, 32'hffff_ffff);
		rd(`VICOM_REG_CTRL, d);
		check(d, `VICOM_CTRL_MASK);
		$display("register test done");
		run(64'h1737, 64'h3333, 4, VICOM_MIX_OFF);
		run(64'h0_1234_5670, 64'h3_3333_3333, 9, VICOM_MIX_HARD);
		run(64'h111_1077, 64'h012_3321, 7, VICOM_MIX_EXT);
		run(64'h0002_2233_3000, 64'h3333_3333_3333, 12, VICOM_MIX_INT);
		run(64'h17, 64'h33, 2, VICOM_MIX_HARD, 5'h1c, 24'h00_0000, 24'h10_8080);
		run(64'h107, 64'h000, 3, VICOM_MIX_HARD, 5'h0b, 24'h00_8410, 24'hb0_8080);
		conclude();
	end
endmodule : vicom_mixer_tb_top

//--- sim/vicom_pix_src.sv
// Pixel and overlay source model for the video input mixer
`timescale 1ns/100ps
module vicom_pix_src (
	input  wire logic   ref_clk_i,
	output logic        pixel_valid_o,
	output logic [23:0] pixel_input_bus_o,
	output logic [2:0]  overlay_color_select_o,
	output logic [1:0]  mix_level_o
);
	// Quiet pins at time zero
	initial begin
		pixel_valid_o = 1'b0;
		pixel_input_bus_o = 24'h00_0000;
		overlay_color_select_o = 3'h0;
		mix_level_o = 2'h0;
	end
	// Present one pixel for one clock; callers keep overlay runs of three in internal mode
	task automatic send(input logic [23:0] px, input logic [2:0] code, input logic [1:0] lv);
		@(posedge ref_clk_i);
		pixel_valid_o <= 1'b1;
		pixel_input_bus_o <= px;
		overlay_color_select_o <= code;
		mix_level_o <= lv;
	endtask : send
	// Idle cycles; released pixel bus and overlay code pins toggle so no stale value survives, mix level keeps its value
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge ref_clk_i);
			pixel_valid_o <= 1'b0;
			pixel_input_bus_o <= ~pixel_input_bus_o;
			overlay_color_select_o <= ~overlay_color_select_o;
		end
	endtask : idle
endmodule : vicom_pix_src

//--- verilog/vicom_gamma.sv
// Per-channel gamma correction table with registered output
`timescale 1ns/100ps
`include "vicom_map.svh"

module vicom_gamma #(
	parameter int DW = 8
) (
	input  wire logic          ref_clk_i,
	input  wire logic          sys_rst_i,
	input  wire logic          adv_i,
	input  wire logic          apply_i,
	input  wire logic          curve_sel_i,
	input  wire logic [DW-1:0] smp_i,
	output logic      [DW-1:0] smp_o
);
	import vicom_pkg::*;

	localparam int NENT = 2 ** DW;

	logic [DW-1:0] curve_a [NENT];
	logic [DW-1:0] curve_b [NENT];
	logic [DW-1:0] smp_q;

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (DW != 8) begin : g_chk
		$error("vicom_gamma: only 8-bit samples are supported");
	end

	// ****************************************************************
	// Tables built at elaboration, one entry per code
	// ****************************************************************
	for (genvar i = 0; i < NENT; i++) begin : g_lut
		localparam real XN = real'(i) / real'(NENT - 1);
		localparam int  VA = int'(real'(NENT - 1) * $pow(XN, 1.0 / `VICOM_GAMMA_A));
		localparam int  VB = int'(real'(NENT - 1) * $pow(XN, 1.0 / `VICOM_GAMMA_B));
		assign curve_a[i] = DW'(VA);
		assign curve_b[i] = DW'(VB);
	end

	// Correct or pass the sample, one pipeline stage
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			smp_q <= '0;
		end else if (adv_i) begin
			if (!apply_i) begin
				smp_q <= smp_i;
			end else if (curve_sel_i) begin
				smp_q <= curve_b[smp_i];
			end else begin
				smp_q <= curve_a[smp_i];
			end
		end
	end

	assign smp_o = smp_q;

endmodule : vicom_gamma

//--- verilog/vicom_mixer.sv
// Video input stage: format capture, gamma, colour conversion, chroma upsampling, overlay mixing
`timescale 1ns/100ps
`include "vicom_map.svh"

// How it works
// [R01] Linear RGB input is gamma corrected with exponent 1/2.2 or 1/2.8 by control bit.
// [R02] RGB, corrected or direct, is converted to 4:4:4 YCbCr.
// [R03] 4:2:2 chroma is upsampled by two using linear interpolation of neighbours.
// [R04] Mixer works on converter output; its result is the block output.
// [R05] Overlay codes 1 to 7 map to fixed palette colours, 7 is full white.
// [R06] Overlay code zero leaves that pixel's own colour.
// [R07] Overlay mixing is suppressed in 24-bit RGB format.
// [R08] Four mixing methods chosen by a control register field.
// [R09] Disabled mixing ignores overlay and mix level inputs.
// [R10] External mode uses the mix level per pixel unless overlay code is zero.
// [R11] Mix levels 00,01,10,11 give 0, 12.5, 87.5, 100 percent overlay.
// [R12] External mode accepts any run length and per-pixel level changes.
// [R13] Internal mode ignores mix level and blends on any selection change.
// [R14] Source holds each overlay colour at least three pixels in internal mode.
// [R15] Software avoids internal mixing with the embedded-sync 8-bit format.
// [R16] Pixel to overlay: 12.5% one pixel early, 87.5% at change, then full.
// [R17] Overlay to pixel: 87.5% on last overlay pixel, 12.5% next, then pixel.
// [R18] Colour to colour: 12.5% new one early, 87.5% at change, then full.
// [R19] Hard mode switches to overlay whenever code is non-zero, no blending.
// [R20] 4:2:2 chroma is time multiplexed, starting with a blue difference sample.
// [R21] 16-bit RGB components are left shifted to 8-bit full scale.
// [R22] One pixel of look-ahead with equal latency in every mixing mode.

module vicom_mixer (
	input  wire logic                 ref_clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic [31:0]          reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [31:0]          reg_rdata_o,
	input  wire logic                 pixel_valid_i,
	input  wire logic [23:0]          pixel_input_bus_i,
	input  wire logic [2:0]           overlay_color_select_i,
	input  wire logic                 mix_level_lsb_i,
	input  wire logic                 mix_level_msb_i,
	output logic                      out_valid_o,
	output vicom_pkg::vicom_smp_t     out_y_o,
	output vicom_pkg::vicom_smp_t     out_cb_o,
	output vicom_pkg::vicom_smp_t     out_cr_o
);
	import vicom_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [31:0]  ctrl_q;
	logic [31:0]  rdata_q;
	logic [29:0]  pin_s1_q;
	logic [29:0]  pin_s2_q;
	vicom_fmt_e   fmt;
	vicom_mix_e   mix;
	logic         byte_mode;
	logic         rgb_mode;
	logic         ovl_ok;
	logic         in_vld;
	logic [23:0]  in_bus;
	logic [1:0]   phase_q;
	vicom_smp_t   chroma_hold_q;
	logic         pix_done;
	logic         adv;
	vicom_smp_t   fe_x [3];
	logic         fe_cb;
	vicom_smp_t   a_x_q [3];
	logic         a_vld_q;
	logic         a_cb_q;
	logic [2:0]   a_ol_q;
	logic [1:0]   a_ml_q;
	vicom_smp_t   b_x [3];
	logic         b_vld_q;
	logic         b_cb_q;
	logic [2:0]   b_ol_q;
	logic [1:0]   b_ml_q;
	vicom_smp_t   bp_c_q;
	logic         bp_vld_q;
	vicom_smp_t   nb_prev;
	vicom_smp_t   nb_next;
	logic [8:0]   csum;
	vicom_smp_t   cc_y;
	vicom_smp_t   cc_cb;
	vicom_smp_t   cc_cr;
	vicom_smp_t   c_y_q;
	vicom_smp_t   c_cb_q;
	vicom_smp_t   c_cr_q;
	logic         c_vld_q;
	logic [2:0]   c_ol_q;
	logic [1:0]   c_ml_q;
	logic [2:0]   cp_ol_q;
	logic [23:0]  col_a;
	logic [23:0]  col_b;
	logic [3:0]   mix_w;
	logic         out_valid_q;
	vicom_smp_t   out_y_q;
	vicom_smp_t   out_cb_q;
	vicom_smp_t   out_cr_q;
	logic [15:0]  out_cnt_q;
	logic         ovl_last_q;

	// ****************************************************************
	// Functions
	// ****************************************************************
	// One output of the colour matrix, rounded and clamped to 8 bits
	function automatic vicom_smp_t csc_ch(input vicom_smp_t r, input vicom_smp_t g, input vicom_smp_t b,
		input logic signed [9:0] kr, input logic signed [9:0] kg, input logic signed [9:0] kb,
		input vicom_smp_t off);
		logic signed [19:0] acc;
		acc = kr * $signed({1'b0, r}) + kg * $signed({1'b0, g}) + kb * $signed({1'b0, b});
		acc = (acc + 20'sd128) >>> 8;
		acc = acc + $signed({12'h000, off});
		if (acc < 0) begin
			return 8'h00;
		end else if (acc > 20'sd255) begin
			return 8'hff;
		end
		return acc[7:0];
	endfunction : csc_ch

	// Palette lookup, code zero yields black and is never blended in
	function automatic logic [23:0] palette(input logic [2:0] code);
		case (code)
			3'h1:    return `VICOM_OVL_BLUE;
			3'h2:    return `VICOM_OVL_RED;
			3'h3:    return `VICOM_OVL_MAGENTA;
			3'h4:    return `VICOM_OVL_GREEN;
			3'h5:    return `VICOM_OVL_CYAN;
			3'h6:    return `VICOM_OVL_YELLOW;
			3'h7:    return `VICOM_OVL_WHITE;
			default: return 24'h00_0000;
		endcase
	endfunction : palette

	// Weighted sum a*w/8 + b*(8-w)/8, rounded
	function automatic vicom_smp_t blend(input vicom_smp_t a, input vicom_smp_t b, input logic [3:0] w);
		logic [11:0] s;
		s = {4'h0, a} * {8'h00, w} + {4'h0, b} * {8'h00, `VICOM_W_FULL - w} + 12'h004;
		return s[10:3];
	endfunction : blend

	// ****************************************************************
	// Register port
	// ****************************************************************
	// Control register write
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= `VICOM_CTRL_RST;
		end else if (reg_wr_i && reg_addr_i == `VICOM_REG_CTRL) begin
			ctrl_q <= reg_wdata_i & `VICOM_CTRL_MASK;
		end
	end

	// Read data for one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`VICOM_REG_CTRL:   rdata_q <= ctrl_q;
				`VICOM_REG_STATUS: rdata_q <= {15'h0000, ovl_last_q, out_cnt_q};
				default:           rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	// Decoded configuration
	assign fmt       = vicom_fmt_e'(ctrl_q[`VICOM_CTRL_FMT]);
	assign mix       = vicom_mix_e'(ctrl_q[`VICOM_CTRL_MIX]); // [R08]
	assign byte_mode = (fmt == VICOM_FMT_YC8) || (fmt == VICOM_FMT_BT656);
	assign rgb_mode  = (fmt == VICOM_FMT_RGB16) || (fmt == VICOM_FMT_RGB24);
	assign ovl_ok    = (fmt != VICOM_FMT_RGB24) && (mix != VICOM_MIX_OFF); // [R07] [R09]

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= {pixel_valid_i, mix_level_msb_i, mix_level_lsb_i, overlay_color_select_i, pixel_input_bus_i};
			pin_s2_q <= pin_s1_q;
		end
	end

	assign in_vld = pin_s2_q[29];
	assign in_bus = pin_s2_q[23:0];

	// ****************************************************************
	// Format capture
	// ****************************************************************
	// Sample phase restarts whenever the source drops valid
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			phase_q       <= 2'h0;
			chroma_hold_q <= 8'h00;
		end else begin
			phase_q <= in_vld ? phase_q + 2'h1 : 2'h0;
			if (in_vld && byte_mode && !phase_q[0]) begin
				chroma_hold_q <= in_bus[15:8]; // Cb or Cr byte
			end
		end
	end

	// Unpack one pixel from the bus
	always_comb begin
		pix_done = in_vld && (!byte_mode || phase_q[0]);
		adv      = pix_done || !in_vld; // Idle cycles push bubbles to flush the pipe
		fe_cb    = byte_mode ? !phase_q[1] : !phase_q[0]; // [R20]
		case (fmt)
			VICOM_FMT_RGB16: begin
				fe_x[0] = {in_bus[15:11], 3'h0}; // [R21]
				fe_x[1] = {in_bus[10:5], 2'h0}; // [R21]
				fe_x[2] = {in_bus[4:0], 3'h0}; // [R21]
			end
			VICOM_FMT_RGB24: begin
				fe_x[0] = in_bus[23:16];
				fe_x[1] = in_bus[15:8];
				fe_x[2] = in_bus[7:0];
			end
			VICOM_FMT_YC8, VICOM_FMT_BT656: begin
				fe_x[0] = in_bus[15:8];
				fe_x[1] = chroma_hold_q;
				fe_x[2] = 8'h00;
			end
			default: begin
				fe_x[0] = in_bus[15:8];
				fe_x[1] = in_bus[7:0];
				fe_x[2] = 8'h00;
			end
		endcase
	end

	// Stage A: captured pixel and its overlay controls
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			a_x_q   <= '{default: 8'h00};
			a_vld_q <= 1'b0;
			a_cb_q  <= 1'b0;
			a_ol_q  <= 3'h0;
			a_ml_q  <= 2'h0;
		end else if (adv) begin
			a_x_q   <= fe_x;
			a_vld_q <= pix_done;
			a_cb_q  <= fe_cb;
			a_ol_q  <= (pix_done && ovl_ok) ? pin_s2_q[26:24] : 3'h0; // [R07] [R09]
			a_ml_q  <= pin_s2_q[28:27];
		end
	end

	// ****************************************************************
	// Stage B: gamma correction
	// ****************************************************************
	for (genvar ch = 0; ch < 3; ch++) begin : g_gamma
		vicom_gamma #(
			.DW (8)
		) u_gamma (
			.ref_clk_i   (ref_clk_i),
			.sys_rst_i   (sys_rst_i),
			.adv_i       (adv),
			.apply_i     (rgb_mode && ctrl_q[`VICOM_CTRL_LIN]), // [R01]
			.curve_sel_i (ctrl_q[`VICOM_CTRL_GSEL]), // [R01]
			.smp_i       (a_x_q[ch]),
			.smp_o       (b_x[ch])
		);
	end

	// Side information and the previous pixel's chroma
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			b_vld_q  <= 1'b0;
			b_cb_q   <= 1'b0;
			b_ol_q   <= 3'h0;
			b_ml_q   <= 2'h0;
			bp_c_q   <= 8'h00;
			bp_vld_q <= 1'b0;
		end else if (adv) begin
			b_vld_q  <= a_vld_q;
			b_cb_q   <= a_cb_q;
			b_ol_q   <= a_ol_q;
			b_ml_q   <= a_ml_q;
			bp_c_q   <= b_x[1];
			bp_vld_q <= b_vld_q;
		end
	end

	// ****************************************************************
	// Stage C: colour conversion and chroma upsampling
	// ****************************************************************
	always_comb begin
		// Missing component is the mean of both neighbours, edges reuse the one present
		nb_prev = bp_vld_q ? bp_c_q : (a_vld_q ? a_x_q[1] : b_x[1]);
		nb_next = a_vld_q ? a_x_q[1] : nb_prev;
		csum    = {1'b0, nb_prev} + {1'b0, nb_next} + 9'h001; // [R03]
		if (rgb_mode) begin
			cc_y  = csc_ch(b_x[0], b_x[1], b_x[2], `VICOM_Y_R, `VICOM_Y_G, `VICOM_Y_B, `VICOM_Y_OFF); // [R02]
			cc_cb = csc_ch(b_x[0], b_x[1], b_x[2], `VICOM_CB_R, `VICOM_CB_G, `VICOM_CB_B, `VICOM_C_OFF); // [R02]
			cc_cr = csc_ch(b_x[0], b_x[1], b_x[2], `VICOM_CR_R, `VICOM_CR_G, `VICOM_CR_B, `VICOM_C_OFF); // [R02]
		end else begin
			cc_y  = b_x[0];
			cc_cb = b_cb_q ? b_x[1] : csum[8:1]; // [R03] [R20]
			cc_cr = b_cb_q ? csum[8:1] : b_x[1]; // [R03] [R20]
		end
	end

	// Converted pixel and the overlay code one pixel older
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			c_y_q   <= 8'h00;
			c_cb_q  <= 8'h00;
			c_cr_q  <= 8'h00;
			c_vld_q <= 1'b0;
			c_ol_q  <= 3'h0;
			c_ml_q  <= 2'h0;
			cp_ol_q <= 3'h0;
		end else if (adv) begin
			c_y_q   <= cc_y;
			c_cb_q  <= cc_cb;
			c_cr_q  <= cc_cr;
			c_vld_q <= b_vld_q;
			c_ol_q  <= b_ol_q;
			c_ml_q  <= b_ml_q;
			cp_ol_q <= c_ol_q; // [R22]
		end
	end

	// ****************************************************************
	// Stage D: overlay mixing
	// ****************************************************************
	// Stage C holds pixel n, stage B pixel n+1, cp_ol_q the code of pixel n-1
	always_comb begin
		col_a = {c_y_q, c_cb_q, c_cr_q}; // [R04]
		col_b = {c_y_q, c_cb_q, c_cr_q}; // [R06]
		mix_w = `VICOM_W_ZERO;
		case (mix)
			VICOM_MIX_EXT: begin
				if (c_ol_q != 3'h0) begin // [R10]
					col_a = palette(c_ol_q); // [R05]
					case (c_ml_q) // [R11] [R12]
						2'b01:   mix_w = `VICOM_W_LOW;
						2'b10:   mix_w = `VICOM_W_HIGH;
						2'b11:   mix_w = `VICOM_W_FULL;
						default: mix_w = `VICOM_W_ZERO;
					endcase
				end
			end
			VICOM_MIX_INT: begin
				// Mix level pins are not looked at here
				if (c_ol_q == 3'h0) begin // [R13]
					if (cp_ol_q != 3'h0) begin
						col_a = palette(cp_ol_q); // [R17]
						mix_w = `VICOM_W_LOW;
					end else if (b_ol_q != 3'h0) begin
						col_a = palette(b_ol_q); // [R16]
						mix_w = `VICOM_W_LOW;
					end
				end else begin
					col_a = palette(c_ol_q);
					if (cp_ol_q != c_ol_q) begin
						if (cp_ol_q != 3'h0) begin
							col_b = palette(cp_ol_q); // [R18]
						end
						mix_w = `VICOM_W_HIGH; // [R16] [R18]
					end else if (b_ol_q == 3'h0) begin
						mix_w = `VICOM_W_HIGH; // [R17]
					end else if (b_ol_q != c_ol_q) begin
						col_a = palette(b_ol_q); // [R18]
						col_b = palette(c_ol_q);
						mix_w = `VICOM_W_LOW;
					end else begin
						mix_w = `VICOM_W_FULL;
					end
				end
			end
			VICOM_MIX_HARD: begin
				if (c_ol_q != 3'h0) begin // [R19]
					col_a = palette(c_ol_q); // [R05]
					mix_w = `VICOM_W_FULL;
				end
			end
			default: begin
				mix_w = `VICOM_W_ZERO; // [R09]
			end
		endcase
	end

	// Registered result, one output per pixel leaving stage C
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			out_valid_q <= 1'b0;
			out_y_q     <= 8'h00;
			out_cb_q    <= 8'h00;
			out_cr_q    <= 8'h00;
		end else begin
			out_valid_q <= adv && c_vld_q; // [R22]
			if (adv && c_vld_q) begin // Data stand until the next output pixel
				out_y_q  <= blend(col_a[23:16], col_b[23:16], mix_w); // [R04]
				out_cb_q <= blend(col_a[15:8], col_b[15:8], mix_w);
				out_cr_q <= blend(col_a[7:0], col_b[7:0], mix_w);
			end
		end
	end

	// Status: output pixel count and whether the last one carried overlay
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			out_cnt_q  <= 16'h0000;
			ovl_last_q <= 1'b0;
		end else if (adv && c_vld_q) begin
			out_cnt_q  <= out_cnt_q + 16'h0001;
			ovl_last_q <= (mix_w != `VICOM_W_ZERO);
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata_o = rdata_q;
	assign out_valid_o = out_valid_q;
	assign out_y_o     = out_y_q;
	assign out_cb_o    = out_cb_q;
	assign out_cr_o    = out_cr_q;

endmodule : vicom_mixer
